// >>> rtl/tc2_pkg.sv
// Constants, register layout and state types of the second control block.
// Assumes a single 10 MHz system clock; every file but the link interface and the host model imports this package.
package tc2_pkg;

  // Register map: one 16-bit word at word address 0x02
  localparam logic [3:0] CR2_ADDR = 4'h2;
  localparam logic [15:0] CR2_RESET = 16'h4040;

  // Field positions inside the control word
  localparam int POL_HI = 15;
  localparam int POL_LO = 14;
  localparam int PIN_EN_BIT = 13;
  localparam int PIN_LVL_BIT = 12;
  localparam int PIN_DIR_BIT = 11;
  localparam int PIN_POL_BIT = 10;
  localparam int REF_BIT = 9;
  localparam int MEAN_HI = 8;
  localparam int MEAN_LO = 7;
  localparam int RANK_HI = 6;
  localparam int RANK_LO = 5;
  localparam int SRST_BIT = 4;
  localparam int FCD_HI = 3;
  localparam int FCD_LO = 0;

  // Power policy codes
  localparam logic [1:0] PP_OFF = 2'h0;
  localparam logic [1:0] PP_AUTO = 2'h1;
  localparam logic [1:0] PP_ON = 2'h2;
  localparam logic [1:0] PP_AUTO2 = 2'h3;

  // Conversion mode codes from the other control register
  localparam logic [1:0] CM_NONE = 2'h0;
  localparam logic [1:0] CM_SINGLE = 2'h1;
  localparam logic [1:0] CM_SLAVE = 2'h2;
  localparam logic [1:0] CM_MASTER = 2'h3;

  // Channel codes; bit 2 set marks the touch-panel channels
  localparam logic [2:0] CH_TEMP = 3'h1;
  localparam logic [2:0] CH_BATT = 3'h2;
  localparam logic [2:0] CH_AUX = 3'h3;
  localparam logic [2:0] CH_PRS2 = 3'h4;
  localparam logic [2:0] CH_PRS1 = 3'h5;
  localparam logic [2:0] CH_YPOS = 3'h6;
  localparam logic [2:0] CH_XPOS = 3'h7;
  localparam int CH_TOUCH_BIT = 2;

  // First-conversion delay: steps of 128 us at a 10 MHz clock
  localparam int FCD_STEP_US = 128;
  localparam int CLK_MHZ = 10;
  localparam int FCD_STEP_CYC = FCD_STEP_US * CLK_MHZ;

  // Request sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_GO = 3'b100
  } tc2_state_e;

endpackage : tc2_pkg

// >>> rtl/tc2_link_if.sv
// Carrier between the control block and its delay timer and power decoder.
// Assumes all three modules run on the same clock and reset.
`timescale 1ns/1ns
interface tc2_link_if;
  logic srst; // One-cycle soft reset to all helpers
  logic dly_start; // Start a first-conversion delay
  logic [3:0] dly_code; // Delay length in 128 us steps minus one
  logic dly_done; // One-cycle pulse when the delay has elapsed
  logic [1:0] policy; // Power policy field
  logic [1:0] conv_mode; // Conversion mode from the other register
  logic touch; // Screen touched
  logic adc_need; // Converter is in use or about to be
  logic temp_need; // Temperature channel is in use
  logic adc_pwr; // Registered power enables
  logic osc_pwr;
  logic bias_pwr;
  logic temp_pwr;

  modport ctrl (output srst, dly_start, dly_code, policy, conv_mode, touch,
    adc_need, temp_need, input dly_done, adc_pwr, osc_pwr, bias_pwr,
    temp_pwr);
  modport tmr (input srst, dly_start, dly_code, output dly_done);
  modport pwr (input srst, policy, conv_mode, touch, adc_need, temp_need,
    output adc_pwr, osc_pwr, bias_pwr, temp_pwr);
endinterface : tc2_link_if

// >>> rtl/tc2_delay_timer.sv
// First-conversion delay timer: waits (code + 1) steps, then pulses done.
// Assumes start is a one-cycle pulse that only comes while the timer idles.
`timescale 1ns/1ns
module tc2_delay_timer
  import tc2_pkg::*;
#(
  parameter int STEP_CYCLES = FCD_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  tc2_link_if.tmr lnk
);

  logic busy_q, busy_d; // Delay in progress
  logic [15:0] cyc_q, cyc_d; // Cycles within the current step
  logic [3:0] stp_q, stp_d; // Steps still to run after this one
  logic done_q, done_d; // Registered completion pulse

  // Step divider and step counter; soft reset abandons a running delay
  always_comb begin
    busy_d = busy_q;
    cyc_d = cyc_q;
    stp_d = stp_q;
    done_d = 1'b0;
    if (lnk.srst) begin
      busy_d = 1'b0;
      cyc_d = 16'h0000;
      stp_d = 4'h0;
    end else if (lnk.dly_start) begin
      busy_d = 1'b1;
      cyc_d = 16'h0000;
      stp_d = lnk.dly_code;
    end else if (busy_q) begin
      if (cyc_q == 16'(STEP_CYCLES - 1)) begin
        // One 128 us step has passed
        cyc_d = 16'h0000;
        if (stp_q == 4'h0) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end else begin
          stp_d = stp_q - 4'h1;
        end
      end else begin
        cyc_d = cyc_q + 16'h0001;
      end
    end
  end

  // Timer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cyc_q <= 16'h0000;
      stp_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      cyc_q <= cyc_d;
      stp_q <= stp_d;
      done_q <= done_d;
    end
  end

  assign lnk.dly_done = done_q;

endmodule // tc2_delay_timer

// >>> rtl/tc2_power_ctrl.sv
// Power decoder: turns policy, conversion mode and demand into enables.
// Assumes the demand inputs rise before the converter is actually used.
`timescale 1ns/1ns
module tc2_power_ctrl
  import tc2_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  tc2_link_if.pwr lnk
);

  logic adc_q, adc_d; // Converter enable
  logic osc_q, osc_d; // Oscillator enable
  logic bias_q, bias_d; // Bias enable
  logic temp_q, temp_d; // Temperature sensor enable
  logic auto_pol; // Policy 01 and 11 behave alike

  assign auto_pol = (lnk.policy == PP_AUTO) || (lnk.policy == PP_AUTO2);

  // Enables from policy; registered so the analog side sees no glitches
  always_comb begin
    adc_d = 1'b0;
    osc_d = 1'b0;
    bias_d = 1'b0;
    temp_d = 1'b0;
    if (lnk.policy == PP_ON) begin
      // Always on; the sensor still only when needed
      adc_d = 1'b1; // [RL4]
      osc_d = 1'b1; // [RL4]
      bias_d = 1'b1; // [RL4]
      temp_d = lnk.temp_need;
    end else if (auto_pol && lnk.conv_mode == CM_MASTER) begin
      // Converter, clock and bias asleep until a touch or demand wakes them
      adc_d = lnk.touch | lnk.adc_need; // [RL2] [RL13]
      osc_d = lnk.touch | lnk.adc_need; // [RL2]
      bias_d = lnk.touch | lnk.adc_need; // [RL2]
      temp_d = lnk.temp_need; // [RL2]
    end else if (auto_pol) begin
      // Clock and bias stay up to keep time between conversions
      osc_d = 1'b1; // [RL3] [RL13]
      bias_d = 1'b1; // [RL3]
      adc_d = lnk.adc_need; // [RL3]
      temp_d = lnk.temp_need; // [RL3]
    end
    // Policy 00 keeps every default of zero: full shutdown [RL1]
  end

  // Enable registers; soft reset drops them with the rest of the logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_q <= 1'b0;
      osc_q <= 1'b0;
      bias_q <= 1'b0;
      temp_q <= 1'b0;
    end else if (lnk.srst) begin
      adc_q <= 1'b0;
      osc_q <= 1'b0;
      bias_q <= 1'b0;
      temp_q <= 1'b0;
    end else begin
      adc_q <= adc_d;
      osc_q <= osc_d;
      bias_q <= bias_d;
      temp_q <= temp_d;
    end
  end

  assign lnk.adc_pwr = adc_q;
  assign lnk.osc_pwr = osc_q;
  assign lnk.bias_pwr = bias_q;
  assign lnk.temp_pwr = temp_q;

endmodule // tc2_power_ctrl

// >>> rtl/tc2_control.sv
// Second control register of the touch-screen converter and its logic:
// power policy, shared pin, filter sizes, first-conversion delay, reset.
// Assumes a register port driven by the serial interface and a sequencer
// that holds CONV_REQ until it sees CONV_GO or CONV_SKIP.
//
// Functional notes
// RL1 - Policy 00 powers everything fully down
// RL2 - Policy 01/11 master: sleep until touch
// RL3 - Policy 01/11 slave/single: clock, bias stay on
// RL4 - Policy 10: converter, bias, oscillator always on
// RL5 - Bit 13 picks analog channel or pin
// RL6 - Bit 10: pin polarity, 0 low active
// RL7 - Bit 9: 0 ratiometric, 1 single-ended
// RL8 - Bits 8:7 choose averaging count
// RL9 - Bits 6:5 choose median window size
// RL10 - Writing bit 4 high resets logic
// RL11 - Bits 3:0 set delay in 128 us steps
// RL12 - Delay before touch channels and first conversion
// RL13 - Conversion mode steers the power policy
// RL14 - Pin mode ignores auxiliary and battery channels
// RL15 - Bit 11 direction, bit 12 pin data
`timescale 1ns/1ns
module tc2_control
  import tc2_pkg::*;
#(
  parameter int STEP_CYCLES = FCD_STEP_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic [1:0] ADC_MODE,
  input wire logic PEN_TOUCH,
  input wire logic CONV_REQ,
  input wire logic [2:0] CONV_CHAN,
  input wire logic CONV_BUSY,
  output logic CONV_GO,
  output logic CONV_SKIP,
  output logic ADC_PWR,
  output logic OSC_PWR,
  output logic BIAS_PWR,
  output logic TEMP_PWR,
  input wire logic GPIO_I,
  output logic GPIO_O,
  output logic GPIO_OE,
  output logic AUX_PIN_ANALOG,
  output logic DIFF_SEL,
  output logic [1:0] MEAN_COUNT,
  output logic [1:0] RANK_SIZE,
  output logic SOFT_RST
);

  tc2_link_if lnk (); // Shared wiring to timer and power decoder
  // New helper signals go into the interface and its modports,
  // not onto extra pins of each helper

  // Register and its fields
  logic [15:0] cr_q, cr_d; // Control word as stored
  logic [1:0] power_policy; // Bits 15:14
  logic pin_en; // Bit 13
  logic shared_pin_level; // Bit 12 as written
  logic pin_dir_in; // Bit 11
  logic shared_pin_polarity; // Bit 10
  logic reference_method_select; // Bit 9
  logic [1:0] sample_mean_count; // Bits 8:7
  logic [1:0] rank_filter_size; // Bits 6:5
  logic [3:0] first_conversion_delay; // Bits 3:0

  // Read path, pin sampling and soft reset pulse
  logic [15:0] rdata_q, rdata_d; // Read data, held until next read
  logic pin_in_q, pin_in_d; // Logical level seen on an input pin
  logic srst_q, srst_d; // One-cycle soft reset
  logic [15:0] rd_word; // Word as seen by a read

  // Request sequencing
  tc2_state_e st_q, st_d; // Sequencer state
  logic first_q, first_d; // A conversion ran since power-up
  logic go_q, go_d; // Registered go pulse
  logic skip_q, skip_d; // Registered skip pulse
  logic ch_touch; // Channel uses the panel
  logic ch_ignored; // Channel dropped while the pin is digital
  logic need_delay; // Settling or power-up wait is due
  logic wr_hit; // Write to this register

  // Field views are plain slices, so every field moves on
  // the same edge as the stored word
  assign power_policy = cr_q[POL_HI:POL_LO];
  assign pin_en = cr_q[PIN_EN_BIT];
  assign shared_pin_level = cr_q[PIN_LVL_BIT];
  assign pin_dir_in = cr_q[PIN_DIR_BIT];
  assign shared_pin_polarity = cr_q[PIN_POL_BIT];
  assign reference_method_select = cr_q[REF_BIT];
  assign sample_mean_count = cr_q[MEAN_HI:MEAN_LO];
  assign rank_filter_size = cr_q[RANK_HI:RANK_LO];
  assign first_conversion_delay = cr_q[FCD_HI:FCD_LO];

  // Only our word address is taken; other writes are ignored
  assign wr_hit = REG_WR && (REG_ADDR == CR2_ADDR);

  // Register write; a write with the reset bit set reloads the default
  // Trade-off: a reset write sets no other field, so the host
  // writes the wanted word afterwards
  always_comb begin
    cr_d = cr_q;
    srst_d = 1'b0;
    if (wr_hit) begin
      if (REG_WDATA[SRST_BIT]) begin
        // Timer, power enables and sequencer restart, this word included
        cr_d = CR2_RESET; // [RL10]
        srst_d = 1'b1; // [RL10]
      end else begin
        cr_d = REG_WDATA;
      end
    end
  end

  // Register storage
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cr_q <= CR2_RESET;
      srst_q <= 1'b0;
    end else begin
      cr_q <= cr_d;
      srst_q <= srst_d;
    end
  end

  // Shared pin: polarity maps logical level to the wire both ways
  // The stored data bit is the logical level; an active-low
  // pin carries its inverse
  always_comb begin
    pin_in_d = shared_pin_polarity ? GPIO_I : ~GPIO_I; // [RL6]
  end

  // Pin sample; pin input is synchronous to the system clock
  // Limitation: no synchroniser here, so an asynchronous
  // source needs one in front of this block
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pin_in_q <= 1'b0;
    end else begin
      pin_in_q <= pin_in_d;
    end
  end

  // Driven only in pin mode with direction set to output
  assign GPIO_OE = pin_en & ~pin_dir_in; // [RL5] [RL15]
  // Active-low polarity inverts the level on the wire
  assign GPIO_O = shared_pin_polarity ? shared_pin_level
                                      : ~shared_pin_level; // [RL6] [RL15]
  assign AUX_PIN_ANALOG = ~pin_en; // [RL5]

  // Read word: an input pin shows its level in the data bit
  // An output pin reads back the stored bit, not the wire
  always_comb begin
    rd_word = cr_q;
    if (pin_en && pin_dir_in) begin
      rd_word[PIN_LVL_BIT] = pin_in_q; // [RL15]
    end
    // Reset bit acts on write only, so it always reads back as zero
    rd_word[SRST_BIT] = 1'b0;
  end

  // Read data latch; other addresses belong to other registers
  // Registered so the serial side sees a steady word until
  // the next read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (REG_RD) begin
      if (REG_ADDR == CR2_ADDR) begin
        rdata_d = rd_word;
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  // Read data register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Channel classification for the sequencer request
  // A skip pulse answers dropped channels, so the sequencer
  // never waits on a channel that is not measured
  assign ch_touch = CONV_CHAN[CH_TOUCH_BIT];
  assign ch_ignored = pin_en &&
    ((CONV_CHAN == CH_AUX) || (CONV_CHAN == CH_BATT)); // [RL14]
  // Panel channels settle; the very first conversion waits for power-up
  assign need_delay = ch_touch || !first_q || !ADC_PWR; // [RL12]

  // Sequencer next state; the delay lets the screen and converter settle
  // Idle takes a request, wait runs the timer, go is a dead
  // cycle in which the requester drops its level
  always_comb begin
    st_d = st_q;
    first_d = first_q;
    go_d = 1'b0;
    skip_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (CONV_REQ && ch_ignored) begin
          // Pin is digital, so this channel is not measured
          skip_d = 1'b1; // [RL14]
          st_d = ST_GO;
        end else if (CONV_REQ && need_delay) begin
          st_d = ST_WAIT; // [RL12]
        end else if (CONV_REQ) begin
          go_d = 1'b1;
          first_d = 1'b1;
          st_d = ST_GO;
        end
      end
      ST_WAIT: begin
        if (lnk.dly_done) begin
          go_d = 1'b1; // [RL12]
          first_d = 1'b1;
          st_d = ST_GO;
        end
      end
      ST_GO: begin
        // One cycle for the sequencer to drop its request
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // Losing converter power means the next conversion is a first one
    // A pending request keeps the flag so its own wait is not cut
    if (!ADC_PWR && st_q == ST_IDLE && !CONV_REQ) begin
      first_d = 1'b0;
    end
    // Soft reset overrides every branch above, a go in flight too
    if (srst_q) begin
      st_d = ST_IDLE;
      first_d = 1'b0;
      go_d = 1'b0;
      skip_d = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= ST_IDLE;
      first_q <= 1'b0;
      go_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      st_q <= st_d;
      first_q <= first_d;
      go_q <= go_d;
      skip_q <= skip_d;
    end
  end

  // Delay starts on the cycle the wait is entered
  // Start is combinational so the timer loads on the same edge
  // as the state change; no cycle is lost at the front
  assign lnk.dly_start = (st_q == ST_IDLE) && (st_d == ST_WAIT);
  assign lnk.dly_code = first_conversion_delay; // [RL11]
  assign lnk.srst = srst_q;
  assign lnk.policy = power_policy; // [RL1]
  assign lnk.conv_mode = ADC_MODE; // [RL13]
  assign lnk.touch = PEN_TOUCH;
  // Demand covers the wait so the converter powers up during it
  assign lnk.adc_need = CONV_BUSY || CONV_REQ || (st_q != ST_IDLE);
  assign lnk.temp_need = CONV_BUSY && (CONV_CHAN == CH_TEMP);

  // Delay timer: counts whole steps of STEP_CYCLES clocks
  tc2_delay_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .lnk(lnk)
  );

  // Power decoder: registered enables, dropped by soft reset
  tc2_power_ctrl u_power (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .lnk(lnk)
  );

  // Outputs; filter and reference fields go straight from the register
  // Limitation: these are not frozen during a conversion, so
  // the host changes them only while the sequencer idles
  assign REG_RDATA = rdata_q;
  assign CONV_GO = go_q;
  assign CONV_SKIP = skip_q;
  assign ADC_PWR = lnk.adc_pwr;
  assign OSC_PWR = lnk.osc_pwr;
  assign BIAS_PWR = lnk.bias_pwr;
  assign TEMP_PWR = lnk.temp_pwr;
  assign DIFF_SEL = ~reference_method_select; // [RL7]
  assign MEAN_COUNT = sample_mean_count; // [RL8]
  assign RANK_SIZE = rank_filter_size; // [RL9]
  assign SOFT_RST = srst_q; // [RL10]

endmodule // tc2_control

// >>> tb/tc2_control_props.sv
// Port checker for the second control block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module tc2_control_props
  import tc2_pkg::*;
#(
  parameter int STEP_CYCLES = FCD_STEP_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic REG_WR,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic CONV_REQ,
  input wire logic [2:0] CONV_CHAN,
  input wire logic CONV_GO,
  input wire logic CONV_SKIP,
  input wire logic ADC_PWR,
  input wire logic OSC_PWR,
  input wire logic BIAS_PWR,
  input wire logic TEMP_PWR,
  input wire logic GPIO_O,
  input wire logic GPIO_OE,
  input wire logic AUX_PIN_ANALOG,
  input wire logic DIFF_SEL,
  input wire logic [1:0] MEAN_COUNT,
  input wire logic [1:0] RANK_SIZE,
  input wire logic SOFT_RST
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // Plain field write; a reset write reloads defaults instead
  logic wr_ok;
  assign wr_ok = REG_WR && (REG_ADDR == CR2_ADDR) && !REG_WDATA[SRST_BIT];
  // Enables are registered after the field, hence the extra cycle
  property p_off;
    wr_ok && REG_WDATA[POL_HI:POL_LO] == PP_OFF |=> ##1
      !(ADC_PWR || OSC_PWR || BIAS_PWR || TEMP_PWR);
  endproperty
  a_off: assert property (p_off) else $error("power not off");
  property p_on;
    wr_ok && REG_WDATA[POL_HI:POL_LO] == PP_ON |=> ##1
      (ADC_PWR && OSC_PWR && BIAS_PWR);
  endproperty
  a_on: assert property (p_on) else $error("power not on");
  // The converter never runs without its clock and bias
  property p_awake;
    ADC_PWR |-> OSC_PWR && BIAS_PWR;
  endproperty
  a_awake: assert property (p_awake) else $error("adc alone");
  property p_pin;
    GPIO_OE |-> !AUX_PIN_ANALOG;
  endproperty
  a_pin: assert property (p_pin) else $error("pin both ways");
  property p_skip;
    CONV_SKIP |-> !$past(AUX_PIN_ANALOG) &&
      ($past(CONV_CHAN) == CH_AUX || $past(CONV_CHAN) == CH_BATT);
  endproperty
  a_skip: assert property (p_skip) else $error("bad skip");
  // Touch channels always see no go for at least five cycles after the request
  property p_settle;
    $rose(CONV_REQ) && CONV_CHAN[CH_TOUCH_BIT] |=> !CONV_GO [*5];
  endproperty
  a_settle: assert property (p_settle) else $error("no settle");
  property p_srst;
    REG_WR && REG_ADDR == CR2_ADDR && REG_WDATA[SRST_BIT] |=> SOFT_RST &&
      RANK_SIZE == 2'h2 && MEAN_COUNT == 2'h0 && DIFF_SEL && !GPIO_OE;
  endproperty
  a_srst: assert property (p_srst) else $error("no soft reset");
  property p_mean;
    wr_ok |=> MEAN_COUNT == $past(REG_WDATA[MEAN_HI:MEAN_LO]);
  endproperty
  a_mean: assert property (p_mean) else $error("mean field");
  property p_rank;
    wr_ok |=> RANK_SIZE == $past(REG_WDATA[RANK_HI:RANK_LO]);
  endproperty
  a_rank: assert property (p_rank) else $error("rank field");
  property p_ref;
    wr_ok |=> DIFF_SEL == !$past(REG_WDATA[REF_BIT]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select");
  property p_gpo;
    wr_ok |=> GPIO_O == ($past(REG_WDATA[PIN_POL_BIT]) ~^
      $past(REG_WDATA[PIN_LVL_BIT]));
  endproperty
  a_gpo: assert property (p_gpo) else $error("pin level");
  property p_oe;
    wr_ok |=> GPIO_OE == ($past(REG_WDATA[PIN_EN_BIT]) &&
      !$past(REG_WDATA[PIN_DIR_BIT]));
  endproperty
  a_oe: assert property (p_oe) else $error("pin direction");
  c_go: cover property (CONV_GO);
  c_skip: cover property (CONV_SKIP);
  c_srst: cover property (SOFT_RST);
endmodule // tc2_control_props

bind tc2_control tc2_control_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
  .CLK_SYS, .RESETN, .REG_WR, .REG_ADDR, .REG_WDATA, .CONV_REQ, .CONV_CHAN,
  .CONV_GO, .CONV_SKIP, .ADC_PWR, .OSC_PWR, .BIAS_PWR, .TEMP_PWR, .GPIO_O,
  .GPIO_OE, .AUX_PIN_ANALOG, .DIFF_SEL, .MEAN_COUNT, .RANK_SIZE, .SOFT_RST);

// >>> tb/tc2_host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes its tasks are called from one bench process only.
`timescale 1ns/1ns
module tc2_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // Idle bus from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
  end
  // Write; released data is scrambled so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask
  // Read; the registered word is taken one edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule // tc2_host_model

// >>> tb/tc2_control_tb_top.sv
// Self-checking bench of the second control block.
// Assumes the host model drives the register port; bench drives the rest.
`timescale 1ns/1ns
module tc2_control_tb_top;
  import tc2_pkg::*;
  localparam int STEP = 4; // Short delay step keeps the run brief
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr, reg_rd, pen_touch, conv_req, conv_busy, gpio_i, gpio_o;
  logic conv_go, conv_skip, adc_pwr, osc_pwr, bias_pwr, temp_pwr, gpio_oe;
  logic aux_pin_analog, diff_sel, soft_rst;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] adc_mode, mean_count, rank_size;
  logic [2:0] conv_chan;
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h07FD;

  tc2_control #(.STEP_CYCLES(STEP)) uut (.CLK_SYS(clk_sys),
    .RESETN(resetn), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .ADC_MODE(adc_mode), .PEN_TOUCH(pen_touch), .CONV_REQ(conv_req),
    .CONV_CHAN(conv_chan), .CONV_BUSY(conv_busy), .CONV_GO(conv_go),
    .CONV_SKIP(conv_skip), .ADC_PWR(adc_pwr), .OSC_PWR(osc_pwr),
    .BIAS_PWR(bias_pwr), .TEMP_PWR(temp_pwr), .GPIO_I(gpio_i),
    .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .AUX_PIN_ANALOG(aux_pin_analog),
    .DIFF_SEL(diff_sel), .MEAN_COUNT(mean_count), .RANK_SIZE(rank_size),
    .SOFT_RST(soft_rst));
  tc2_host_model host (.clk(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // 100 ns period
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Repeatable xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Readback: reset bit reads 0, an input pin shows its level
  function automatic logic [15:0] exp_rd(logic [15:0] d, logic gi);
    logic [15:0] e;
    e = d & 16'hFFEF;
    if (d[PIN_EN_BIT] && d[PIN_DIR_BIT]) e[PIN_LVL_BIT] = d[PIN_POL_BIT] ~^ gi;
    return e;
  endfunction
  // Idle enables {adc, osc, bias, temp} for policy, mode and touch
  function automatic logic [3:0] exp_pwr(logic [1:0] p, logic [1:0] m,
    logic t);
    if (p == PP_OFF) return 4'h0;
    if (p == PP_ON) return 4'hE;
    if (m == CM_MASTER) return {t, t, t, 1'b0};
    return 4'h6;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Request a conversion; result is {skip, edges from take to answer}
  task automatic conv(input logic [2:0] ch, output logic [31:0] res);
    int k;
    @(posedge clk_sys);
    conv_req <= 1'b1;
    conv_chan <= ch;
    for (k = 0; k < 200; k++) begin
      @(posedge clk_sys);
      #1;
      if (conv_go || conv_skip) break;
    end
    if (k == 200) begin
      n_fail++;
      end_sim();
    end
    res = {conv_skip, 31'(k + 1)};
    conv_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] d, q, q2;
    logic [7:0] e;
    logic [3:0] n, ep;
    logic gi;
    adc_mode = CM_NONE;
    pen_touch = 1'b0;
    conv_req = 1'b0;
    conv_chan = CH_TEMP;
    conv_busy = 1'b0;
    gpio_i = 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    // Defaults, then a write to an unmapped place
    host.rd(CR2_ADDR, q);
    host.wr(4'h5, 16'hFFEF);
    host.rd(4'h5, q2);
    chk({q, q2}, {16'h4040, 16'h0000});
    // Random field words with both extreme words first
    for (int i = 0; i < 8; i++) begin
      r = xs();
      gi = r[16];
      d = (i == 0) ? 16'hFFEF : (i == 1) ? 16'h0000 : r[15:0];
      d[SRST_BIT] = 1'b0;
      @(posedge clk_sys);
      gpio_i <= gi;
      host.wr(CR2_ADDR, d);
      e = {d[8:7], d[6:5], ~d[9], d[13] & ~d[11], d[10] ~^ d[12], ~d[13]};
      q = {8'h00, mean_count, rank_size, diff_sel, gpio_oe, gpio_o,
        aux_pin_analog};
      chk(q, e);
      host.rd(CR2_ADDR, q);
      chk(q, exp_rd(d, gi));
    end
    // Every policy against every mode, touched and not, while idle
    for (int p = 0; p < 4; p++) begin
      host.wr(CR2_ADDR, {p[1:0], 14'h0040});
      for (int m = 0; m < 8; m++) begin
        @(posedge clk_sys);
        adc_mode <= m[1:0];
        pen_touch <= m[2];
        repeat (3) @(posedge clk_sys);
        #1;
        ep = exp_pwr(p[1:0], m[1:0], m[2]);
        n = {adc_pwr, osc_pwr, bias_pwr, temp_pwr};
        chk(n, ep);
      end
    end
    // Delay codes 0, 15 and random, each after a soft reset
    adc_mode <= CM_SINGLE;
    pen_touch <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      r = xs();
      n = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : r[3:0];
      host.wr(CR2_ADDR, 16'h0010);
      host.wr(CR2_ADDR, {12'h800, n});
      repeat (2) @(posedge clk_sys);
      conv(CH_TEMP, r);
      chk(r, (32'(n) + 1) * STEP + 2);
      conv(CH_TEMP, r);
      chk(r, 32'h1);
      conv(3'(7 - i), r);
      chk(r, (32'(n) + 1) * STEP + 2);
    end
    // Pin mode drops auxiliary and battery requests
    host.wr(CR2_ADDR, 16'hA000);
    conv(CH_AUX, r);
    chk(r, 32'h80000001);
    conv(CH_BATT, r);
    chk(r, 32'h80000001);
    host.wr(CR2_ADDR, 16'h8000);
    conv(CH_AUX, r);
    chk(r, 32'h1);
    // Busy temperature conversion wakes sensor and converter
    host.wr(CR2_ADDR, 16'h4000);
    @(posedge clk_sys);
    conv_chan <= CH_TEMP;
    conv_busy <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({temp_pwr, adc_pwr}, 2'h3);
    @(posedge clk_sys);
    conv_busy <= 1'b0;
    // Reset bit reloads defaults and reads back as zero
    host.wr(CR2_ADDR, 16'hFFFF);
    host.rd(CR2_ADDR, q);
    chk(q, 16'h4040);
    end_sim();
  end
endmodule // tc2_control_tb_top
